//--- design/rtc_cfg.svh
// Register map, field positions and timing counts of the RTC counter block
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers
// What this block does
// - Second counter registers read only while counter ready is set.
// - Counter writes take effect only with clock run enable and busy both clear.
// - Time count ripples from an 8-bit sub-second stage into a 32-bit second count.
// - High second register shows second count bits 31 to 16.
// - Low second register shows second count bits 15 to 0.
// - Second count cleared only by power-on reset, kept through other resets.
// - Sub-second reload and time-of-day high alarm clear on every reset.
// - Sub-second reload always readable, writable only while its alarm is disabled.
// - Time-of-day high alarm always readable, writable only while its alarm is disabled.
// - Sub-second reload register gives the value the sub-second timer reloads.
// - Every sub-second timer auto-reload sets the sub-second alarm flag.
// - Sub-second counter steps at 256 Hz; its rollover advances the second count.
// - Time-of-day alarm fires on rollover when low 20 bits of alarm and seconds match.
// - Set sub-second flag requests interrupt when enabled; software clears the flag.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// Register indices; byte address is four times the index
`define RTC_IDX_SUBSEC    8'h1A
`define RTC_IDX_SEC_HIGH  8'h1B
`define RTC_IDX_SEC_LOW   8'h1C
`define RTC_IDX_SS_RELOAD 8'h1D
`define RTC_IDX_TOD_HIGH  8'h1E
`define RTC_IDX_TOD_LOW   8'h1F
`define RTC_IDX_CTRL      8'h20
// Control and status bit positions
`define RTC_BIT_RUN       0
`define RTC_BIT_SS_EN     1
`define RTC_BIT_TOD_EN    2
`define RTC_BIT_BUSY      3
`define RTC_BIT_READY     4
`define RTC_BIT_TOD_FLAG  6
`define RTC_BIT_SS_FLAG   7
// Reset values
`define RTC_RST_SEC       32'h0000_0000
`define RTC_RST_BYTE      8'h00
// Source 32.768 kHz edges per 256 Hz tick, and busy cycles after a counter write
`define RTC_SRC_HZ        32768
`define RTC_TICK_HZ       256
`define RTC_DIV_TICKS     (`RTC_SRC_HZ / `RTC_TICK_HZ)
`define RTC_BUSY_CYCLES   2'h2
// AXI responses
`define RTC_RESP_OKAY     2'h0
`define RTC_RESP_SLVERR   2'h2
`define RTC_RESP_DECERR   2'h3
`endif

//--- design/rtc_pkg.sv
// Types shared by the RTC counter block
// Assumes rtc_cfg.svh is on the include path
package rtc_pkg;
  typedef logic [7:0] reg_idx_t;
  typedef struct packed {
    logic [2:0]  sync;
    logic        level;
    logic [7:0]  div;
    logic [7:0]  sub;
    logic [31:0] sec;
    logic [7:0]  ssReload;
    logic [7:0]  alarmTimer;
    logic [3:0]  todHigh;
    logic [15:0] todLow;
    logic        runEn;
    logic        ssEn;
    logic        todEn;
    logic        ssFlag;
    logic        todFlag;
    logic [1:0]  busyCnt;
    logic        irq;
    logic        awHeld;
    reg_idx_t    awIdx;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } rtc_state_s;
endpackage : rtc_pkg

//--- design/rtc_counter_alarm_regs.sv
// RTC second counter, sub-second alarm and time-of-day alarm registers
// Assumes a 32.768 kHz source pin, one core clock and an AXI4-Lite master
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_counter_alarm_regs #(
  parameter int ADDR_W = 12,
  parameter int DIV    = `RTC_DIV_TICKS
) (
  // Clock and resets
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 porRst,
  // Counter source pin
  input  wire logic                 clk32kIn,
  // AXI4-Lite write
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  // AXI4-Lite read
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic [2:0]           arprot,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  // Status
  output logic                      alarmIrq,
  output logic                      counterReady,
  output logic                      counterBusy
);
  import rtc_pkg::*;

  rtc_state_s q;
  rtc_state_s d;
  logic       edge32;
  logic       tick;
  logic       roll;
  logic       doWrite;
  logic       wrCount;
  logic       wrSub;
  logic [31:0] secNext;
  reg_idx_t   arIdx;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  assign awready      = !q.awHeld;
  assign wready       = !q.wHeld;
  assign arready      = !q.rValid;
  assign bvalid       = q.bValid;
  assign bresp        = q.bResp;
  assign rvalid       = q.rValid;
  assign rdata        = q.rData;
  assign rresp        = q.rResp;
  assign alarmIrq     = q.irq;
  assign counterBusy  = q.busyCnt != 2'h0;
  assign counterReady = q.busyCnt == 2'h0;
  assign arIdx        = araddr[ADDR_W-1:2] < 10'h100 ? araddr[9:2] : 8'hFF;

  always_comb begin
    d       = q;
    edge32  = 1'b0;
    doWrite = q.awHeld && q.wHeld && !q.bValid;
    wrCount = 1'b0;
    wrSub   = 1'b0;
    // Source pin: a rising change counts once the second and third stages agree
    d.sync = {q.sync[1:0], clk32kIn};
    if (q.sync[1] == q.sync[2] && q.sync[2] != q.level) begin
      d.level = q.sync[2];
      edge32  = q.sync[2];
    end
    tick = 1'b0;
    if (q.runEn && edge32) begin
      if (q.div == 8'(DIV - 1)) begin
        d.div = 8'h00;
        tick  = 1'b1;
      end else begin
        d.div = q.div + 8'h01;
      end
    end
    roll    = tick && q.sub == 8'hFF;
    secNext = q.sec + 32'h1;
    if (tick) begin
      d.sub = q.sub + 8'h01;
    end
    if (roll) begin
      d.sec = secNext;
    end
    // Sub-second alarm timer reloads from the reload register when it expires
    if (!q.ssEn) begin
      d.alarmTimer = q.ssReload;
    end else if (tick) begin
      if (q.alarmTimer == 8'h00) begin
        d.alarmTimer = q.ssReload;
      end else begin
        d.alarmTimer = q.alarmTimer - 8'h01;
      end
    end
    if (q.busyCnt != 2'h0) begin
      d.busyCnt = q.busyCnt - 2'h1;
    end
    // Write channel
    if (awvalid && !q.awHeld) begin
      d.awHeld = 1'b1;
      d.awIdx  = awaddr[ADDR_W-1:2] < 10'h100 ? awaddr[9:2] : 8'hFF;
    end
    if (wvalid && !q.wHeld) begin
      d.wHeld = 1'b1;
      d.wData = wdata;
      d.wStrb = wstrb;
    end
    if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end
    if (doWrite) begin
      d.awHeld = 1'b0;
      d.wHeld  = 1'b0;
      d.bValid = 1'b1;
      d.bResp  = `RTC_RESP_OKAY;
      wrCount  = !q.runEn && q.busyCnt == 2'h0;
      case (q.awIdx)
        `RTC_IDX_SUBSEC: begin
          if (wrCount) begin
            wrSub = q.wStrb[0];
            if (q.wStrb[0]) d.sub = q.wData[7:0];
          end else begin
            d.bResp = `RTC_RESP_SLVERR;
          end
        end
        `RTC_IDX_SEC_HIGH: begin
          if (wrCount) d.sec[31:16] = merge16(q.sec[31:16], q.wData[15:0], q.wStrb[1:0]);
          else d.bResp = `RTC_RESP_SLVERR;
        end
        `RTC_IDX_SEC_LOW: begin
          if (wrCount) d.sec[15:0] = merge16(q.sec[15:0], q.wData[15:0], q.wStrb[1:0]);
          else d.bResp = `RTC_RESP_SLVERR;
        end
        `RTC_IDX_SS_RELOAD: begin
          if (!q.ssEn) begin
            if (q.wStrb[0]) d.ssReload = q.wData[7:0];
          end else begin
            d.bResp = `RTC_RESP_SLVERR;
          end
        end
        `RTC_IDX_TOD_HIGH: begin
          if (!q.todEn) begin
            if (q.wStrb[0]) d.todHigh = q.wData[3:0];
          end else begin
            d.bResp = `RTC_RESP_SLVERR;
          end
        end
        `RTC_IDX_TOD_LOW: begin
          d.todLow = merge16(q.todLow, q.wData[15:0], q.wStrb[1:0]);
        end
        `RTC_IDX_CTRL: begin
          if (q.wStrb[0]) begin
            d.runEn = q.wData[`RTC_BIT_RUN];
            d.ssEn  = q.wData[`RTC_BIT_SS_EN];
            d.todEn = q.wData[`RTC_BIT_TOD_EN];
            // Flags clear on a written zero
            if (!q.wData[`RTC_BIT_TOD_FLAG]) d.todFlag = 1'b0;
            if (!q.wData[`RTC_BIT_SS_FLAG])  d.ssFlag  = 1'b0;
          end
        end
        default: d.bResp = `RTC_RESP_DECERR;
      endcase
      if (wrCount && (q.awIdx == `RTC_IDX_SUBSEC || q.awIdx == `RTC_IDX_SEC_HIGH ||
                      q.awIdx == `RTC_IDX_SEC_LOW)) begin
        d.busyCnt = `RTC_BUSY_CYCLES;
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (q.ssEn && tick && q.alarmTimer == 8'h00) begin
      d.ssFlag = 1'b1;
    end
    if (roll && {q.todHigh, q.todLow} == secNext[19:0]) begin
      d.todFlag = 1'b1;
    end
    d.irq = (d.ssFlag && d.ssEn) || (d.todFlag && d.todEn);
    // Read channel
    if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end
    if (arvalid && !q.rValid) begin
      d.rValid = 1'b1;
      d.rData  = 32'h0000_0000;
      d.rResp  = `RTC_RESP_OKAY;
      case (arIdx)
        `RTC_IDX_SUBSEC: begin
          if (counterReady) d.rData = {24'h00_0000, q.sub};
          else d.rResp = `RTC_RESP_SLVERR;
        end
        `RTC_IDX_SEC_HIGH: begin
          if (counterReady) d.rData = {16'h0000, q.sec[31:16]};
          else d.rResp = `RTC_RESP_SLVERR;
        end
        `RTC_IDX_SEC_LOW: begin
          if (counterReady) d.rData = {16'h0000, q.sec[15:0]};
          else d.rResp = `RTC_RESP_SLVERR;
        end
        `RTC_IDX_SS_RELOAD: d.rData = {24'h00_0000, q.ssReload};
        `RTC_IDX_TOD_HIGH:  d.rData = {28'h000_0000, q.todHigh};
        `RTC_IDX_TOD_LOW:   d.rData = {16'h0000, q.todLow};
        `RTC_IDX_CTRL: begin
          d.rData[`RTC_BIT_RUN]      = q.runEn;
          d.rData[`RTC_BIT_SS_EN]    = q.ssEn;
          d.rData[`RTC_BIT_TOD_EN]   = q.todEn;
          d.rData[`RTC_BIT_BUSY]     = counterBusy;
          d.rData[`RTC_BIT_READY]    = counterReady;
          d.rData[`RTC_BIT_TOD_FLAG] = q.todFlag;
          d.rData[`RTC_BIT_SS_FLAG]  = q.ssFlag;
        end
        default: d.rResp = `RTC_RESP_DECERR;
      endcase
    end
    // Any reset clears alarms, control and bus; counters only on power-on
    if (sys_rst || porRst) begin
      d.sync       = 3'h0;
      d.level      = 1'b0;
      d.ssReload   = `RTC_RST_BYTE;
      d.todHigh    = 4'h0;
      d.todLow     = 16'h0000;
      d.alarmTimer = `RTC_RST_BYTE;
      d.runEn      = 1'b0;
      d.ssEn       = 1'b0;
      d.todEn      = 1'b0;
      d.ssFlag     = 1'b0;
      d.todFlag    = 1'b0;
      d.busyCnt    = 2'h0;
      d.irq        = 1'b0;
      d.awHeld     = 1'b0;
      d.awIdx      = 8'h00;
      d.wHeld      = 1'b0;
      d.wData      = 32'h0000_0000;
      d.wStrb      = 4'h0;
      d.bValid     = 1'b0;
      d.bResp      = 2'h0;
      d.rValid     = 1'b0;
      d.rData      = 32'h0000_0000;
      d.rResp      = 2'h0;
    end
    if (porRst) begin
      d.div = 8'h00;
      d.sub = `RTC_RST_BYTE;
      d.sec = `RTC_RST_SEC;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst || porRst);

  // Read gating, register views, counting, alarms and resets
  chk_read_gate: assert property (
    arvalid && arready && arIdx == `RTC_IDX_SEC_HIGH && !counterReady
    |=> rvalid && rresp == `RTC_RESP_SLVERR && rdata == 32'h0)
    else $error("counter read served while not ready");
  chk_high_view: assert property (
    arvalid && arready && arIdx == `RTC_IDX_SEC_HIGH && counterReady
    |=> rdata == {16'h0000, $past(q.sec[31:16])})
    else $error("high register shows wrong half");
  chk_low_view: assert property (
    arvalid && arready && arIdx == `RTC_IDX_SEC_LOW && counterReady
    |=> rdata == {16'h0000, $past(q.sec[15:0])})
    else $error("low register shows wrong half");
  chk_write_gate: assert property (
    q.runEn && !roll |=> q.sec == $past(q.sec))
    else $error("second count changed while running without rollover");
  chk_ripple_carry: assert property (
    tick && q.sub == 8'hFF |=> q.sub == 8'h00 && q.sec == $past(q.sec) + 32'h1)
    else $error("rollover did not carry into seconds");
  chk_hold_stopped: assert property (
    !q.runEn && !wrSub |=> q.sub == $past(q.sub))
    else $error("sub-second count moved while stopped");
  chk_tick_step: assert property (
    tick && q.sub != 8'hFF |=> q.sub == $past(q.sub) + 8'h01)
    else $error("sub-second count did not step on tick");
  chk_reload_flag: assert property (
    q.ssEn && tick && q.alarmTimer == 8'h00
    |=> q.ssFlag && q.alarmTimer == $past(q.ssReload))
    else $error("auto-reload missed flag or value");
  chk_reload_lock: assert property (
    q.ssEn |=> $stable(q.ssReload))
    else $error("reload changed while its alarm enabled");
  chk_tod_lock: assert property (
    q.todEn |=> $stable(q.todHigh))
    else $error("alarm high changed while alarm enabled");
  chk_tod_match: assert property (
    roll && {q.todHigh, q.todLow} == secNext[19:0] |=> q.todFlag)
    else $error("time-of-day match did not set flag");
  chk_irq_request: assert property (
    q.ssEn && tick && q.alarmTimer == 8'h00 && !doWrite
    |=> q.ssFlag && alarmIrq)
    else $error("enabled sub-second flag raised no interrupt");
  chk_keep_count: assert property (@(posedge core_clk) disable iff (porRst)
    sys_rst |=> q.sec == $past(q.sec))
    else $error("second count lost on non power-on reset");
  chk_alarm_reset: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> q.ssReload == 8'h00 && q.todHigh == 4'h0)
    else $error("alarm registers not cleared by reset");

  // Write gating and busy window as seen from the bus
  chk_count_refused: assert property (
    doWrite && q.runEn && (q.awIdx == `RTC_IDX_SEC_HIGH || q.awIdx == `RTC_IDX_SEC_LOW)
    |=> bvalid && bresp == `RTC_RESP_SLVERR)
    else $error("counter write accepted while running");
  chk_busy_span: assert property (
    doWrite && wrCount && (q.awIdx == `RTC_IDX_SEC_HIGH || q.awIdx == `RTC_IDX_SEC_LOW)
    |=> counterBusy ##1 counterBusy ##1 counterReady)
    else $error("busy window after counter write has wrong length");
  // Reload and alarm high writes land only while their alarm is disabled
  chk_reload_write: assert property (
    doWrite && !q.ssEn && q.awIdx == `RTC_IDX_SS_RELOAD && q.wStrb[0]
    |=> q.ssReload == $past(q.wData[7:0]))
    else $error("reload write lost while alarm disabled");
  chk_tod_write: assert property (
    doWrite && !q.todEn && q.awIdx == `RTC_IDX_TOD_HIGH && q.wStrb[0]
    |=> q.todHigh == $past(q.wData[3:0]))
    else $error("alarm high write lost while alarm disabled");
  // Only a control write or a reset may clear a raised sub-second flag
  chk_flag_hold: assert property (
    q.ssFlag && !(doWrite && q.awIdx == `RTC_IDX_CTRL)
    |=> q.ssFlag)
    else $error("sub-second flag dropped without a software clear");

  // Main scenarios reached by the bench
  cov_busy_read: cover property (rvalid && rresp == `RTC_RESP_SLVERR);
  cov_rollover: cover property (roll);
  cov_reload:   cover property (q.ssEn && tick && q.alarmTimer == 8'h00);
  cov_refused:  cover property (bvalid && bresp == `RTC_RESP_SLVERR);
  cov_tod_hit:  cover property (roll && {q.todHigh, q.todLow} == secNext[19:0]);
endmodule : rtc_counter_alarm_regs

//--- test/rtc_counter_alarm_regs_tb.sv
// Self-checking bench for the RTC counter and alarm registers
// Assumes the design's AXI4-Lite slave timing and a shortened tick divider
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_counter_alarm_regs_tb;
  import rtc_pkg::*;
  localparam logic [11:0] A_SUB = 12'h068, A_HI = 12'h06C, A_LO = 12'h070;
  localparam logic [11:0] A_RLD = 12'h074, A_TDH = 12'h078, A_TDL = 12'h07C;
  localparam logic [11:0] A_CTL = 12'h080, A_BAD = 12'h100;
  logic        core_clk, sys_rst, porRst, clk32kIn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        alarmIrq, counterReady, counterBusy;
  int          errorCnt, checksDone;

  rtc_counter_alarm_regs #(.ADDR_W(12), .DIV(2)) rtc_counter_alarm_regs_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .porRst(porRst), .clk32kIn(clk32kIn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .alarmIrq(alarmIrq), .counterReady(counterReady), .counterBusy(counterBusy));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic conclude;
    if (errorCnt == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic check_data(input logic [31:0] g, input logic [31:0] e);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_data

  task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
    checksDone++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_resp

  task automatic timed_out;
    errorCnt++;
    conclude();
  endtask : timed_out

  // Sampling at the falling edge sees what the next rising edge will take
  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic aw, w, b, ta, tw, tb;
    logic [1:0] r;
    @(posedge core_clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    aw = 1'b1; w = 1'b1; b = 1'b1; r = 2'h1;
    for (n = 0; n < 100 && b; n++) begin
      @(negedge core_clk);
      ta = aw && awready === 1'b1;
      tw = w && wready === 1'b1;
      tb = bvalid === 1'b1;
      if (tb) r = bresp;
      @(posedge core_clk);
      if (ta) begin awvalid <= 1'b0; aw = 1'b0; end
      if (tw) begin wvalid <= 1'b0; w = 1'b0; end
      if (tb) begin bready <= 1'b0; b = 1'b0; end
    end
    if (b) timed_out();
    check_resp(r, e);
  endtask : wr_chk

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] e);
    int n;
    logic ar, rv, ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    ar = 1'b1; rv = 1'b1;
    for (n = 0; n < 100 && rv; n++) begin
      @(negedge core_clk);
      ta = ar && arready === 1'b1;
      tr = rvalid === 1'b1;
      if (tr) begin
        d = rdata;
        r = rresp;
      end
      @(posedge core_clk);
      if (ta) begin arvalid <= 1'b0; ar = 1'b0; end
      if (tr) begin rready <= 1'b0; rv = 1'b0; end
    end
    if (rv) timed_out();
    check_resp(r, e);
    check_data(d, ed);
  endtask : rd_chk

  task automatic wait_ready;
    int n;
    for (n = 0; n < 50 && counterReady !== 1'b1; n++) @(negedge core_clk);
    if (counterReady !== 1'b1) timed_out();
  endtask : wait_ready

  // Each source period spans thirteen core cycles, well above the synchroniser depth
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge core_clk) clk32kIn <= 1'b1;
      repeat (6) @(posedge core_clk);
      clk32kIn <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask : pulses

  task automatic t_reset_values;
    rd_chk(A_LO, 32'h0, `RTC_RESP_OKAY);
    rd_chk(A_HI, 32'h0, `RTC_RESP_OKAY);
    rd_chk(A_RLD, 32'h0, `RTC_RESP_OKAY);
    rd_chk(A_TDH, 32'h0, `RTC_RESP_OKAY);
    rd_chk(A_BAD, 32'h0, `RTC_RESP_DECERR);
    wr_chk(A_BAD, 32'h0, `RTC_RESP_DECERR);
  endtask : t_reset_values

  task automatic t_count_write;
    int n;
    wr_chk(A_HI, 32'h0001, `RTC_RESP_OKAY);
    wait_ready();
    wr_chk(A_LO, 32'hFFFF, `RTC_RESP_OKAY);
    wait_ready();
    wr_chk(A_SUB, 32'hFE, `RTC_RESP_OKAY);
    wait_ready();
    rd_chk(A_HI, 32'h0001, `RTC_RESP_OKAY);
    rd_chk(A_LO, 32'hFFFF, `RTC_RESP_OKAY);
    // A read issued inside the busy window after a counter write is refused
    fork
      wr_chk(A_LO, 32'hFFFF, `RTC_RESP_OKAY);
      begin
        for (n = 0; n < 20 && counterBusy !== 1'b1; n++) @(negedge core_clk);
        if (counterBusy !== 1'b1) timed_out();
        check_data({30'h0, counterBusy, counterReady}, 32'h2);
        rd_chk(A_HI, 32'h0, `RTC_RESP_SLVERR);
      end
    join
    wait_ready();
    @(negedge core_clk);
    check_data({30'h0, counterBusy, counterReady}, 32'h1);
  endtask : t_count_write

  task automatic t_run_carry;
    wr_chk(A_CTL, 32'h01, `RTC_RESP_OKAY);
    wr_chk(A_LO, 32'h0, `RTC_RESP_SLVERR);
    pulses(4);
    wr_chk(A_CTL, 32'h00, `RTC_RESP_OKAY);
    rd_chk(A_SUB, 32'h00, `RTC_RESP_OKAY);
    rd_chk(A_LO, 32'h0000, `RTC_RESP_OKAY);
    rd_chk(A_HI, 32'h0002, `RTC_RESP_OKAY);
    pulses(4);
    rd_chk(A_SUB, 32'h00, `RTC_RESP_OKAY);
  endtask : t_run_carry

  task automatic t_ss_alarm;
    wr_chk(A_RLD, 32'h03, `RTC_RESP_OKAY);
    rd_chk(A_RLD, 32'h03, `RTC_RESP_OKAY);
    wr_chk(A_CTL, 32'h03, `RTC_RESP_OKAY);
    wr_chk(A_RLD, 32'h05, `RTC_RESP_SLVERR);
    rd_chk(A_RLD, 32'h03, `RTC_RESP_OKAY);
    pulses(8);
    wr_chk(A_CTL, 32'h82, `RTC_RESP_OKAY);
    rd_chk(A_CTL, 32'h92, `RTC_RESP_OKAY);
    @(negedge core_clk);
    check_data({31'h0, alarmIrq}, 32'h1);
    wr_chk(A_CTL, 32'h02, `RTC_RESP_OKAY);
    rd_chk(A_CTL, 32'h12, `RTC_RESP_OKAY);
    @(negedge core_clk);
    check_data({31'h0, alarmIrq}, 32'h0);
  endtask : t_ss_alarm

  task automatic t_tod_alarm;
    wr_chk(A_CTL, 32'h00, `RTC_RESP_OKAY);
    wr_chk(A_SUB, 32'hFF, `RTC_RESP_OKAY);
    wr_chk(A_TDH, 32'hF2, `RTC_RESP_OKAY);
    rd_chk(A_TDH, 32'h02, `RTC_RESP_OKAY);
    wr_chk(A_TDL, 32'h0001, `RTC_RESP_OKAY);
    rd_chk(A_TDL, 32'h0001, `RTC_RESP_OKAY);
    wr_chk(A_CTL, 32'h04, `RTC_RESP_OKAY);
    wr_chk(A_TDH, 32'h09, `RTC_RESP_SLVERR);
    rd_chk(A_TDH, 32'h02, `RTC_RESP_OKAY);
    wr_chk(A_CTL, 32'h05, `RTC_RESP_OKAY);
    pulses(2);
    wr_chk(A_CTL, 32'h44, `RTC_RESP_OKAY);
    rd_chk(A_CTL, 32'h54, `RTC_RESP_OKAY);
    rd_chk(A_LO, 32'h0001, `RTC_RESP_OKAY);
    @(negedge core_clk);
    check_data({31'h0, alarmIrq}, 32'h1);
  endtask : t_tod_alarm

  task automatic t_resets;
    wr_chk(A_CTL, 32'h00, `RTC_RESP_OKAY);
    wr_chk(A_RLD, 32'h07, `RTC_RESP_OKAY);
    wr_chk(A_TDH, 32'h05, `RTC_RESP_OKAY);
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(A_LO, 32'h0001, `RTC_RESP_OKAY);
    rd_chk(A_RLD, 32'h00, `RTC_RESP_OKAY);
    rd_chk(A_TDH, 32'h00, `RTC_RESP_OKAY);
    @(posedge core_clk) porRst <= 1'b1;
    repeat (2) @(posedge core_clk);
    porRst <= 1'b0;
    rd_chk(A_LO, 32'h0000, `RTC_RESP_OKAY);
  endtask : t_resets

  initial begin
    errorCnt = 0; checksDone = 0;
    sys_rst = 1'b1; porRst = 1'b1; clk32kIn = 1'b0;
    awvalid = 1'b0; awaddr = 12'h0; wvalid = 1'b0; wdata = 32'h0; wstrb = 4'hF;
    bready = 1'b0; arvalid = 1'b0; araddr = 12'h0; rready = 1'b0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    porRst <= 1'b0;
    t_reset_values();
    t_count_write();
    t_run_carry();
    t_ss_alarm();
    t_tod_alarm();
    t_resets();
    conclude();
  end
endmodule : rtc_counter_alarm_regs_tb
